// ==== hdl/adcsc_map.vh ====
`ifndef ADCSC_MAP_VH
`define ADCSC_MAP_VH
// register offsets
`define ADCSC_AW 6
`define ADCSC_DW 16
`define ADCSC_A_CTL0 6'h00
`define ADCSC_A_CTL1 6'h01
`define ADCSC_A_CTL2 6'h02
`define ADCSC_A_CTL3 6'h03
`define ADCSC_A_CTL4 6'h04
`define ADCSC_A_CTL5 6'h05
`define ADCSC_A_STAT0 6'h06
`define ADCSC_A_CMPE 6'h08
`define ADCSC_A_CMPD 6'h09
`define ADCSC_A_CCF 6'h0b
`define ADCSC_A_RES_BASE 3'h2
// reset values
`define ADCSC_CTL1_RST 8'h07
`define ADCSC_CTL4_RST 8'h01
// control fields
`define ADCSC_F_TSRC 2:0
`define ADCSC_B_FAST_FLAG_CLEAR_ENABLE 6
`define ADCSC_B_TLVL 4
`define ADCSC_B_TPOL 3
`define ADCSC_B_TEN 2
`define ADCSC_F_SLEN 6:3
`define ADCSC_F_STIME 7:4
`define ADCSC_B_RES10 0
`define ADCSC_B_SCAN 5
`define ADCSC_F_SCH 2:0
// status fields
`define ADCSC_B_SDONE 7
`define ADCSC_B_TOVR 5
`define ADCSC_B_ROVR 4
// timing and sizes
`define ADCSC_CHANNELS 8
`define ADCSC_FULL_SEQ 4'h8
`define ADCSC_MIN_SAMPLE 4'h4
`define ADCSC_SETTLE 6
`endif

// ==== hdl/adcsc_sync3.v ====
`timescale 1ns/1ns
`default_nettype none
module adcsc_sync3 #(
  parameter W = 9
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // asynchronous levels in, filtered levels out
  input wire [W-1:0] async_in,
  output reg [W-1:0] lvl_q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  wire [W-1:0] agree;

  assign agree = ~(s2_q ^ s3_q);

  always @(posedge mclk) begin
    if (rst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      lvl_q <= {W{1'b0}};
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a level only moves once two stages agree, so a single glitch is dropped
      lvl_q <= (s2_q & agree) | (lvl_q & ~agree);
    end
  end
endmodule
`default_nettype wire

// ==== hdl/adcsc_sar.v ====
`timescale 1ns/1ns
`default_nettype none
`include "adcsc_map.vh"
module adcsc_sar #(
  parameter SETTLE = `ADCSC_SETTLE
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // control
  input wire start,
  input wire abort,
  input wire res10,
  // comparator, already synchronised
  input wire cmp_above,
  // results
  output reg [9:0] trial_q,
  output reg done_q,
  output reg [9:0] result_q
);
  reg busy_q;
  reg [3:0] bit_q;
  reg [7:0] cnt_q;
  wire [9:0] mask;
  wire [9:0] kept;

  assign mask = 10'h001 << bit_q;
  assign kept = cmp_above ? trial_q : (trial_q & ~mask);

  always @(posedge mclk) begin
    if (rst) begin
      busy_q <= 1'b0;
      bit_q <= 4'h0;
      cnt_q <= 8'h00;
      trial_q <= 10'h000;
      done_q <= 1'b0;
      result_q <= 10'h000;
    end else if (abort) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      trial_q <= 10'h000;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= 8'h00;
        bit_q <= res10 ? 4'h9 : 4'h7;
        trial_q <= res10 ? 10'h200 : 10'h080;
      end else if (busy_q) begin
        // settle must exceed the comparator synchroniser latency
        if (cnt_q == SETTLE[7:0] - 8'h01) begin
          cnt_q <= 8'h00;
          if (bit_q == 4'h0) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            result_q <= kept;
            trial_q <= 10'h000;
          end else begin
            bit_q <= bit_q - 4'h1;
            trial_q <= kept | (mask >> 1);
          end
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/adcsc_top.v ====
// Summary of operation
// - one of eight inputs routed to sampler
// - resolution selectable, 8 or 10 bits
// - successive approximation, one bit per step
// - engine powered only while sampling or converting
// - input connected in sample, released in hold
// - trigger source resets to channel 7
// - sequence done sets per completed sequence
// - done clears: write one, start, fast read
// - extra trigger edge while busy flags overrun in edge mode
// - result overwritten before read flags overrun
// - control writes abort, clearing both overruns
// - overruns clear by write one or start
// - status writes leave counter bits untouched
// - status at offset 0x6, always readable
`timescale 1ns/1ns
`default_nettype none
`include "adcsc_map.vh"
module adcsc_top #(
  parameter SETTLE = `ADCSC_SETTLE
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // register port
  input wire [`ADCSC_AW-1:0] addr,
  input wire [`ADCSC_DW-1:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [`ADCSC_DW-1:0] rd_data_q,
  // analog front end
  input wire [`ADCSC_CHANNELS-1:0] ext_in,
  input wire cmp_above,
  output reg [2:0] mux_sel_q,
  output reg sample_en_q,
  output reg power_on_q,
  output wire [9:0] dac_code_q
);
  localparam ST_IDLE = 3'h0;
  localparam ST_WAIT = 3'h1;
  localparam ST_SAMPLE = 3'h2;
  localparam ST_CONV = 3'h3;

  function is_result;
    input [`ADCSC_AW-1:0] a;
    begin
      is_result = (a[5:3] == `ADCSC_A_RES_BASE);
    end
  endfunction

  // every write that reconfigures the converter aborts a running sequence
  function is_abort;
    input [`ADCSC_AW-1:0] a;
    begin
      is_abort = (a == `ADCSC_A_CTL0) || (a == `ADCSC_A_CTL1) || (a == `ADCSC_A_CTL2) ||
                 (a == `ADCSC_A_CTL3) || (a == `ADCSC_A_CTL4) || (a == `ADCSC_A_CMPE) ||
                 (a == `ADCSC_A_CMPD);
    end
  endfunction

  // control registers
  reg [7:0] ctl0_q;
  reg [7:0] trigger_source_control_q;
  reg [7:0] ctl2_q;
  reg [7:0] ctl3_q;
  reg [7:0] ctl4_q;
  reg [7:0] sequence_start_control_q;
  reg [7:0] compare_enable_register_q;
  reg [7:0] compare_direction_register_q;
  // status
  reg sequence_done_flag_q;
  reg trigger_overrun_flag_q;
  reg result_overrun_flag_q;
  reg [3:0] conv_cnt_q;
  reg [7:0] conversion_complete_flag_q;
  reg [9:0] res_mem [0:`ADCSC_CHANNELS-1];
  // sequencer
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [4:0] samp_cnt_q;
  reg trig_prev_q;

  wire [8:0] sync_lvl;
  wire sar_done;
  wire [9:0] sar_result;

  wire wr_abort = wr_en && is_abort(addr);
  wire wr_start = wr_en && (addr == `ADCSC_A_CTL5);
  wire wr_stat = wr_en && (addr == `ADCSC_A_STAT0);
  wire wr_ccf = wr_en && (addr == `ADCSC_A_CCF);
  wire fast_flag_clear_enable = ctl2_q[`ADCSC_B_FAST_FLAG_CLEAR_ENABLE];
  wire rd_res = rd_en && is_result(addr);
  wire [2:0] rd_idx = addr[2:0];

  wire trig_en = ctl2_q[`ADCSC_B_TEN];
  wire trigger_level_select = ctl2_q[`ADCSC_B_TLVL];
  wire trig_pol = ctl2_q[`ADCSC_B_TPOL];
  wire scan = sequence_start_control_q[`ADCSC_B_SCAN];
  wire res10 = ctl4_q[`ADCSC_B_RES10];
  wire [4:0] samp_len = {1'b0, `ADCSC_MIN_SAMPLE} + {1'b0, ctl4_q[`ADCSC_F_STIME]};
  wire [3:0] seq_len = (ctl3_q[`ADCSC_F_SLEN] == 4'h0) ? `ADCSC_FULL_SEQ : ctl3_q[`ADCSC_F_SLEN];

  // trigger source picked after synchronisation of every candidate input
  wire trig_raw = sync_lvl[trigger_source_control_q[`ADCSC_F_TSRC]];
  wire trig_act = trig_pol ? trig_raw : ~trig_raw;
  wire trig_edge = trig_act & ~trig_prev_q;
  wire trig_go = trigger_level_select ? trig_act : trig_edge;
  wire busy = (state_q == ST_SAMPLE) || (state_q == ST_CONV);
  wire trig_ovr_ev = trig_en && !trigger_level_select && trig_edge && busy;

  wire sar_start = (state_q == ST_SAMPLE) && (samp_cnt_q == samp_len);
  wire conv_done = (state_q == ST_CONV) && sar_done;
  wire seq_last = (conv_cnt_q + 4'h1) == seq_len;
  wire [2:0] res_idx = conv_cnt_q[2:0];
  wire res_ovr_ev = conv_done && conversion_complete_flag_q[res_idx];
  wire seq_done_ev = conv_done && seq_last;

  // per-slot complete flags: set by a stored result, cleared by write one, fast read or start
  wire [`ADCSC_CHANNELS-1:0] wr_slot_hot = 8'h01 << res_idx;
  wire [`ADCSC_CHANNELS-1:0] rd_slot_hot = 8'h01 << rd_idx;
  wire [`ADCSC_CHANNELS-1:0] ccf_set;
  wire [`ADCSC_CHANNELS-1:0] ccf_clr;
  genvar g;
  generate
    for (g = 0; g < `ADCSC_CHANNELS; g = g + 1) begin : g_ccf
      assign ccf_set[g] = conv_done & wr_slot_hot[g];
      assign ccf_clr[g] = (wr_ccf & wr_data[g]) | (rd_res & fast_flag_clear_enable & rd_slot_hot[g]) | wr_start;
    end
  endgenerate

  adcsc_sync3 #(
    .W(9)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in({cmp_above, ext_in}),
    .lvl_q(sync_lvl)
  );

  adcsc_sar #(
    .SETTLE(SETTLE)
  ) u_sar (
    .mclk(mclk),
    .rst(rst),
    .start(sar_start),
    .abort(wr_abort | wr_start),
    .res10(res10),
    .cmp_above(sync_lvl[8]),
    .trial_q(dac_code_q),
    .done_q(sar_done),
    .result_q(sar_result)
  );

  // sequencer next state
  always @* begin
    state_d = state_q;
    if (wr_abort) begin
      state_d = ST_IDLE;
    end else if (wr_start) begin
      state_d = trig_en ? ST_WAIT : ST_SAMPLE;
    end else begin
      case (state_q)
        ST_WAIT: begin
          if (trig_go) begin
            state_d = ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (sar_start) begin
            state_d = ST_CONV;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            if (seq_last && !scan) begin
              state_d = ST_IDLE;
            end else if (trig_en && trigger_level_select) begin
              // level mode only starts each conversion while the trigger is active
              state_d = ST_WAIT;
            end else begin
              state_d = ST_SAMPLE;
            end
          end
        end
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      samp_cnt_q <= 5'h00;
      mux_sel_q <= 3'h0;
      sample_en_q <= 1'b0;
      power_on_q <= 1'b0;
    end else begin
      state_q <= state_d;
      power_on_q <= (state_d == ST_SAMPLE) || (state_d == ST_CONV);
      sample_en_q <= (state_d == ST_SAMPLE);
      if (state_q == ST_SAMPLE && state_d == ST_SAMPLE) begin
        samp_cnt_q <= samp_cnt_q + 5'h01;
      end else begin
        samp_cnt_q <= 5'h00;
      end
      if (wr_start) begin
        mux_sel_q <= wr_data[`ADCSC_F_SCH];
      end else if (conv_done) begin
        mux_sel_q <= seq_last ? sequence_start_control_q[`ADCSC_F_SCH] : mux_sel_q + 3'h1;
      end
    end
  end

  // starts at the active level that the idle pin shows out of reset, so no false edge follows reset
  always @(posedge mclk) begin
    if (rst) begin
      trig_prev_q <= 1'b1;
    end else begin
      trig_prev_q <= trig_act;
    end
  end

  // software registers
  always @(posedge mclk) begin
    if (rst) begin
      ctl0_q <= 8'h00;
      trigger_source_control_q <= `ADCSC_CTL1_RST;
      ctl2_q <= 8'h00;
      ctl3_q <= 8'h00;
      ctl4_q <= `ADCSC_CTL4_RST;
      sequence_start_control_q <= 8'h00;
      compare_enable_register_q <= 8'h00;
      compare_direction_register_q <= 8'h00;
    end else if (wr_en) begin
      case (addr)
        `ADCSC_A_CTL0: ctl0_q <= wr_data[7:0];
        `ADCSC_A_CTL1: trigger_source_control_q <= wr_data[7:0];
        `ADCSC_A_CTL2: ctl2_q <= wr_data[7:0];
        `ADCSC_A_CTL3: ctl3_q <= wr_data[7:0];
        `ADCSC_A_CTL4: ctl4_q <= wr_data[7:0];
        `ADCSC_A_CTL5: sequence_start_control_q <= wr_data[7:0];
        `ADCSC_A_CMPE: compare_enable_register_q <= wr_data[7:0];
        `ADCSC_A_CMPD: compare_direction_register_q <= wr_data[7:0];
        default: begin
        end
      endcase
    end
  end

  // flags: a hardware set in the same cycle as a clear always wins
  always @(posedge mclk) begin
    if (rst) begin
      sequence_done_flag_q <= 1'b0;
      trigger_overrun_flag_q <= 1'b0;
      result_overrun_flag_q <= 1'b0;
      conversion_complete_flag_q <= 8'h00;
    end else begin
      sequence_done_flag_q <= seq_done_ev | (sequence_done_flag_q & ~((wr_stat & wr_data[`ADCSC_B_SDONE]) |
                              wr_start | (rd_res & fast_flag_clear_enable)));
      trigger_overrun_flag_q <= trig_ovr_ev | (trigger_overrun_flag_q & ~((wr_stat & wr_data[`ADCSC_B_TOVR]) |
                                wr_start | wr_abort));
      result_overrun_flag_q <= res_ovr_ev | (result_overrun_flag_q & ~((wr_stat & wr_data[`ADCSC_B_ROVR]) |
                               wr_start | wr_abort));
      conversion_complete_flag_q <= ccf_set | (conversion_complete_flag_q & ~ccf_clr);
    end
  end

  // counter: status writes never reach it
  always @(posedge mclk) begin
    if (rst) begin
      conv_cnt_q <= 4'h0;
    end else if (wr_start) begin
      conv_cnt_q <= 4'h0;
    end else if (conv_done) begin
      conv_cnt_q <= seq_last ? 4'h0 : conv_cnt_q + 4'h1;
    end
  end

  // result store; no reset, contents are only meaningful with their flag
  always @(posedge mclk) begin
    if (conv_done) begin
      res_mem[res_idx] <= sar_result;
    end
  end

  // read data live for exactly one cycle after the strobe
  always @(posedge mclk) begin
    if (rst) begin
      rd_data_q <= 16'h0000;
    end else if (!rd_en) begin
      rd_data_q <= 16'h0000;
    end else if (is_result(addr)) begin
      rd_data_q <= {6'h00, res_mem[rd_idx]};
    end else begin
      case (addr)
        `ADCSC_A_CTL0: rd_data_q <= {8'h00, ctl0_q};
        `ADCSC_A_CTL1: rd_data_q <= {8'h00, trigger_source_control_q};
        `ADCSC_A_CTL2: rd_data_q <= {8'h00, ctl2_q};
        `ADCSC_A_CTL3: rd_data_q <= {8'h00, ctl3_q};
        `ADCSC_A_CTL4: rd_data_q <= {8'h00, ctl4_q};
        `ADCSC_A_CTL5: rd_data_q <= {8'h00, sequence_start_control_q};
        `ADCSC_A_STAT0: rd_data_q <= {8'h00, sequence_done_flag_q, 1'b0, trigger_overrun_flag_q,
                                      result_overrun_flag_q, conv_cnt_q};
        `ADCSC_A_CMPE: rd_data_q <= {8'h00, compare_enable_register_q};
        `ADCSC_A_CMPD: rd_data_q <= {8'h00, compare_direction_register_q};
        `ADCSC_A_CCF: rd_data_q <= {8'h00, conversion_complete_flag_q};
        default: rd_data_q <= 16'h0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== tb/adcsc_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module adcsc_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [5:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] rd_data_q,
  // analog front end
  input wire logic [7:0] ext_in,
  input wire logic cmp_above,
  input wire logic [2:0] mux_sel_q,
  input wire logic sample_en_q,
  input wire logic power_on_q,
  input wire logic [9:0] dac_code_q
);
  logic trig_en_q;
  // a start only runs at once while the external trigger is off
  wire start_req = wr_en && addr == 6'h05 && !trig_en_q;
  wire abort_req = wr_en && (addr <= 6'h04 || addr == 6'h08 || addr == 6'h09);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  always @(posedge mclk) begin
    if (rst)
      trig_en_q <= 1'b0;
    else if (wr_en && addr == 6'h02)
      trig_en_q <= wr_data[2];
  end
  sequence s_sampling;
    (power_on_q && sample_en_q) [*5];
  endsequence
  sequence s_holding;
    ($stable(mux_sel_q) && !sample_en_q) [*6];
  endsequence
  chk_rd_idle: assert property (!$past(rd_en) |-> rd_data_q == 16'h0000)
    else $error("read data not zero outside a read");
  chk_stat_upper: assert property (rd_en && addr == 6'h06 |=> rd_data_q[15:8] == 8'h00 && !rd_data_q[6])
    else $error("status unused bits set");
  chk_start_sample: assert property (start_req |=> mux_sel_q == $past(wr_data[2:0]) ##0 s_sampling)
    else $error("start did not open the sample phase");
  chk_hold_mux: assert property ($fell(sample_en_q) && power_on_q |-> s_holding)
    else $error("channel moved during hold");
  chk_sample_power: assert property (sample_en_q |-> power_on_q)
    else $error("sampling while powered down");
  chk_idle_dac: assert property (!power_on_q |-> dac_code_q == 10'h000)
    else $error("trial code while idle");
  chk_abort_idle: assert property (abort_req |-> ##[1:2] !power_on_q)
    else $error("control write did not abort");
  chk_trial_step: assert property ($changed(dac_code_q) && power_on_q |=> ($stable(dac_code_q) || !power_on_q) [*4])
    else $error("trial code changed too soon");
endmodule
bind adcsc_top adcsc_sva u_sva (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data_q(rd_data_q), .ext_in(ext_in), .cmp_above(cmp_above), .mux_sel_q(mux_sel_q),
  .sample_en_q(sample_en_q), .power_on_q(power_on_q), .dac_code_q(dac_code_q));
`default_nettype wire

// ==== tb/adcsc_afe_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module adcsc_afe_model (
  // clock
  input wire logic mclk,
  // bench side, channel 0 in the low bits
  input wire logic [79:0] chan_lvl,
  input wire logic trig,
  // device side
  input wire logic [2:0] mux_sel_q,
  input wire logic sample_en_q,
  input wire logic [9:0] dac_code_q,
  output logic [7:0] ext_in,
  output logic cmp_above
);
  logic [9:0] held_q = 10'h000;
  // the node tracks only while connected, so a wrong hold spoils the result
  always @(posedge mclk) begin
    if (sample_en_q)
      held_q <= chan_lvl[mux_sel_q * 10 +: 10];
  end
  // levels sit half a step above their code, so no tie can occur
  assign cmp_above = {held_q, 1'b1} > {dac_code_q, 1'b0};
  assign ext_in = {trig, 7'h00};
endmodule
`default_nettype wire

// ==== tb/test_adc_sequence_status_control.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_adc_sequence_status_control;
  localparam int SETTLE = 6;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic trig = 1'b0;
  wire [15:0] rd_data_q;
  wire [7:0] ext_in;
  wire cmp_above;
  wire [2:0] mux_sel_q;
  wire sample_en_q;
  wire power_on_q;
  wire [9:0] dac_code_q;
  wire [79:0] chan_lvl = {10'h3ff, 10'h001, 10'h25a, 10'h13a, 10'h2c5, 10'h0f0, 10'h155, 10'h000};
  int error_cnt = 0;
  int comparisons = 0;
  int p1, p2, s1, i;
  logic [15:0] v;

  always #2 mclk = ~mclk;

  adcsc_top #(.SETTLE(SETTLE)) u_dut (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .ext_in(ext_in), .cmp_above(cmp_above),
    .mux_sel_q(mux_sel_q), .sample_en_q(sample_en_q), .power_on_q(power_on_q), .dac_code_q(dac_code_q));
  adcsc_afe_model u_afe (.mclk(mclk), .chan_lvl(chan_lvl), .trig(trig), .mux_sel_q(mux_sel_q),
    .sample_en_q(sample_en_q), .dac_code_q(dac_code_q), .ext_in(ext_in), .cmp_above(cmp_above));

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    d = rd_data_q;
  endtask

  task automatic expect_rd(input logic [5:0] a, input logic [15:0] e);
    rd(a, v);
    chk(v, e);
  endtask

  task automatic wait_done;
    v = 16'h0000;
    for (int n = 0; n < 300 && v[7] !== 1'b1; n++)
      rd(6'h06, v);
    if (v[7] !== 1'b1) begin
      error_cnt++;
      stop_test();
    end
  endtask

  // one single-conversion sequence; counts powered and sampling cycles
  task automatic run_one(output int p, output int s);
    p = 0;
    s = 0;
    wr(6'h05, 16'h0000);
    #1;
    for (int n = 0; n < 2000 && power_on_q === 1'b1; n++) begin
      p++;
      s += sample_en_q;
      @(posedge mclk);
      #1;
    end
    if (power_on_q !== 1'b0) begin
      error_cnt++;
      stop_test();
    end
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    expect_rd(6'h06, 16'h0000);
    expect_rd(6'h01, 16'h0007);
    expect_rd(6'h07, 16'h0000);
    wr(6'h03, 16'h0010);
    wr(6'h05, 16'h0003);
    wait_done();
    expect_rd(6'h06, 16'h0080);
    expect_rd(6'h10, 16'h02c5);
    expect_rd(6'h11, 16'h013a);
    wr(6'h06, 16'h000f);
    expect_rd(6'h06, 16'h0080);
    wr(6'h06, 16'h0080);
    expect_rd(6'h06, 16'h0000);
    wr(6'h05, 16'h0003);
    expect_rd(6'h06, 16'h0000);
    wait_done();
    wr(6'h02, 16'h0040);
    expect_rd(6'h10, 16'h02c5);
    expect_rd(6'h06, 16'h0000);
    wr(6'h02, 16'h0000);
    wr(6'h05, 16'h0023);
    wait_done();
    wr(6'h06, 16'h0080);
    wait_done();
    rd(6'h06, v);
    chk(v & 16'h00b0, 16'h0090);
    wr(6'h00, 16'h0000);
    rd(6'h06, v);
    chk(v & 16'h0030, 16'h0000);
    // edge mode, rising, source left at its reset choice
    wr(6'h02, 16'h000c);
    wr(6'h05, 16'h0003);
    repeat (10) @(posedge mclk);
    #1;
    chk({15'h0000, power_on_q}, 16'h0000);
    trig <= 1'b1;
    for (i = 0; i < 20 && power_on_q !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk({15'h0000, power_on_q}, 16'h0001);
    repeat (8) @(posedge mclk);
    trig <= 1'b0;
    repeat (8) @(posedge mclk);
    trig <= 1'b1;
    repeat (8) @(posedge mclk);
    trig <= 1'b0;
    wait_done();
    rd(6'h06, v);
    chk(v & 16'h00b0, 16'h00a0);
    wr(6'h06, 16'h0020);
    rd(6'h06, v);
    chk(v & 16'h00b0, 16'h0080);
    wr(6'h05, 16'h0000);
    expect_rd(6'h06, 16'h0000);
    wr(6'h02, 16'h0000);
    wr(6'h03, 16'h0008);
    run_one(p1, s1);
    chk(16'(s1), 16'h0005);
    wr(6'h04, 16'h0000);
    run_one(p2, s1);
    chk(16'(p1 - p2), 16'(2 * SETTLE));
    wr(6'h04, 16'h0021);
    run_one(p2, s1);
    chk(16'(s1), 16'h0007);
    // level mode: a conversion only starts while the trigger is held active
    wr(6'h02, 16'h001c);
    wr(6'h03, 16'h0010);
    wr(6'h05, 16'h0002);
    trig <= 1'b1;
    repeat (20) @(posedge mclk);
    trig <= 1'b0;
    repeat (100) @(posedge mclk);
    #1;
    chk({15'h0000, power_on_q}, 16'h0000);
    expect_rd(6'h06, 16'h0001);
    wr(6'h06, 16'h00bf);
    expect_rd(6'h06, 16'h0001);
    wr(6'h05, 16'h0002);
    expect_rd(6'h06, 16'h0000);
    trig <= 1'b1;
    wait_done();
    expect_rd(6'h06, 16'h0080);
    expect_rd(6'h10, 16'h00f0);
    expect_rd(6'h11, 16'h02c5);
    stop_test();
  end
endmodule
`default_nettype wire
